// File: hdl/bus_watchdog_powerfail_timer.sv
/*
 * Timer with a bus watchdog mode and a battery power-fail mode, reached
 * over AXI4-Lite. Assumes a 40 MHz clock, asynchronous serial bus pins
 * and an asynchronous battery-mode indicator.
 */
`timescale 1ns/1ps
module bus_watchdog_powerfail_timer
	import timer_pkg::*;
#(
	parameter int unsigned TICK_CYC_SEL1 = TICK_SEL1_CYC,
	parameter int unsigned TICK_CYC_SEL2 = TICK_SEL2_CYC,
	parameter int unsigned TICK_CYC_SEL3 = TICK_SEL3_CYC,
	parameter int unsigned IRQ_HOLD_CYC = IRQ_HOLD_CYC_DEF,
	parameter logic [7:0] DEF_PRESCALE = DEF_PRESCALE_COUNT
) (
	// Clock, reset and enable.
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CE_IN,
	// AXI4-Lite write channels.
	input wire logic [7:0] AXI_AWADDR_IN,
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	output logic [1:0] AXI_BRESP_OUT,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	// AXI4-Lite read channels.
	input wire logic [7:0] AXI_ARADDR_IN,
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	// Monitored pins.
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic BATTERY_MODE_IN,
	// Interrupt.
	output logic TIMER_IRQ_N_OUT
);

	// State, bus and decode signals.
	logic [5:0] ctrl_ff;
	logic [7:0] timer_target_ff, prescale_target_ff, timer_count_ff;
	logic [7:0] prescale_count_ff, pt;
	logic timer_flag_ff, en_q_ff, run_ff, expired_ff, hold_ff, wd_low_ff;
	logic timer_irq_n_ff, bvalid_ff, rvalid_ff, start_pulse, battery;
	logic [1:0] bresp_ff, rresp_ff, timer_clock_select;
	logic [31:0] hold_cnt_ff, tick_cnt_ff, rdata_ff, rd_word, tick_period;
	logic timer_enable, timer_irq_enable, pf_mode, en_rise, wr_fire, rd_fire;
	logic flag_clear, tick, pre_ovf, wd_go, pf_go, wd_pause, step;
	logic wd_expire, pf_expire, rd_hit;

	// Pin synchroniser and start-condition detector.
	timer_pin_sync pins (
		.clk_in(CLK_IN),
		.reset_n_in(RESET_N_IN),
		.ce_in(CE_IN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.battery_in(BATTERY_MODE_IN),
		.start_pulse_out(start_pulse),
		.battery_out(battery)
	);

	// Control fields and bus handshakes.
	assign timer_enable = ctrl_ff[CTRL_EN_BIT];
	assign timer_clock_select = ctrl_ff[CTRL_SEL_LSB +: 2];
	assign timer_irq_enable = ctrl_ff[CTRL_IRQEN_BIT];
	assign pf_mode = ctrl_ff[CTRL_PF_BIT];
	assign en_rise = timer_enable && !en_q_ff;
	assign wr_fire = CE_IN && AXI_AWVALID_IN && AXI_WVALID_IN && !bvalid_ff;
	assign rd_fire = CE_IN && AXI_ARVALID_IN && !rvalid_ff;
	assign AXI_AWREADY_OUT = wr_fire;
	assign AXI_WREADY_OUT = wr_fire;
	assign AXI_ARREADY_OUT = rd_fire;
	assign AXI_BVALID_OUT = bvalid_ff;
	assign AXI_BRESP_OUT = bresp_ff;
	assign AXI_RVALID_OUT = rvalid_ff;
	assign AXI_RRESP_OUT = rresp_ff;
	assign AXI_RDATA_OUT = rdata_ff;
	assign TIMER_IRQ_N_OUT = timer_irq_n_ff;
	assign flag_clear = wr_fire && AXI_AWADDR_IN == STATUS_OFS &&
		AXI_WSTRB_IN[0] && !AXI_WDATA_IN[0];

	// Tick source and prescaler overflow; select 00 gives no ticks.
	always_comb begin
		unique case (timer_clock_select)
			2'h1: tick_period = TICK_CYC_SEL1;
			2'h2: tick_period = TICK_CYC_SEL2;
			2'h3: tick_period = TICK_CYC_SEL3;
			2'h0: tick_period = 32'h0;
		endcase
	end
	assign tick = tick_period != 32'h0 &&
		tick_cnt_ff == tick_period - 32'h1;
	assign pt = (prescale_target_ff == 8'h00) ? DEF_PRESCALE :
		prescale_target_ff;
	assign pre_ovf = prescale_count_ff >= pt;
	assign wd_go = run_ff && !pf_mode && timer_clock_select != 2'h0;
	assign pf_go = run_ff && pf_mode && timer_clock_select != 2'h0 &&
		battery && !expired_ff;
	assign wd_pause = hold_ff && !wd_low_ff;
	assign step = tick && ((wd_go && !wd_pause) || pf_go);
	assign wd_expire = wd_go && step && pre_ovf &&
		timer_count_ff >= timer_target_ff;
	assign pf_expire = pf_go && step && pre_ovf &&
		timer_count_ff == COUNT_MAX - 8'h01;

	// Tick divider, cleared while the clock select is 00.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			tick_cnt_ff <= 32'h0;
		end else if (CE_IN) begin
			if (tick_period == 32'h0 || tick) begin
				tick_cnt_ff <= 32'h0;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 32'h1;
			end
		end
	end

	// Software-written configuration.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			ctrl_ff <= CTRL_RST;
			timer_target_ff <= TARGET_RST;
			prescale_target_ff <= PTARGET_RST;
		end else if (wr_fire && AXI_WSTRB_IN[0]) begin
			unique case (AXI_AWADDR_IN)
				CTRL_OFS: ctrl_ff <= AXI_WDATA_IN[5:0];
				TARGET_OFS: timer_target_ff <= AXI_WDATA_IN[7:0];
				PTARGET_OFS: prescale_target_ff <= AXI_WDATA_IN[7:0];
				default: ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// Run state: a watchdog enabled with target zero stays off.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			en_q_ff <= 1'b0;
			run_ff <= 1'b0;
		end else if (CE_IN) begin
			en_q_ff <= timer_enable;
			if (!timer_enable) begin
				run_ff <= 1'b0;
			end else if (en_rise) begin
				run_ff <= pf_mode || timer_target_ff != 8'h00;
			end
		end
	end

	// Main counter and prescaler.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			timer_count_ff <= COUNT_RST;
			prescale_count_ff <= PCOUNT_RST;
		end else if (CE_IN) begin
			if (!timer_enable) begin
				timer_count_ff <= COUNT_RST;
				prescale_count_ff <= PCOUNT_RST;
			end else if (en_rise) begin
				timer_count_ff <= {7'h0, !pf_mode && timer_target_ff != 8'h00};
				prescale_count_ff <= PCOUNT_RST;
			end else if (flag_clear && pf_mode && expired_ff) begin
				timer_count_ff <= 8'h01;
				prescale_count_ff <= PCOUNT_RST;
			end else if (wd_go && start_pulse) begin
				timer_count_ff <= 8'h01;
				prescale_count_ff <= PCOUNT_RST;
			end else if (pf_go && timer_count_ff == COUNT_RST) begin
				timer_count_ff <= 8'h01;
			end else if (step) begin
				if (pre_ovf) begin
					prescale_count_ff <= PCOUNT_RST;
					timer_count_ff <= wd_expire ? 8'h01 :
						timer_count_ff + 8'h01;
				end else begin
					prescale_count_ff <= prescale_count_ff + 8'h01;
				end
			end
			// Leaving battery needs no branch: the count simply holds.
		end
	end

	// Sticky status flag; a new expiry wins over a clear in the same cycle.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			timer_flag_ff <= 1'b0;
		end else if (CE_IN) begin
			if (wd_expire || pf_expire) begin
				timer_flag_ff <= 1'b1;
			end else if (flag_clear) begin
				timer_flag_ff <= 1'b0;
			end
		end
	end

	// Power-fail single shot: stops until flag clear or enable toggle.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			expired_ff <= 1'b0;
		end else if (CE_IN) begin
			if (pf_expire) begin
				expired_ff <= 1'b1;
			end else if (flag_clear || !timer_enable) begin
				expired_ff <= 1'b0;
			end
		end
	end

	// Watchdog low pulse: ends at prescaler overflow or at the 210 ms cap;
	// an early end pauses counting until the cap has run out.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			hold_ff <= 1'b0;
			wd_low_ff <= 1'b0;
			hold_cnt_ff <= 32'h0;
		end else if (CE_IN) begin
			if (!wd_go) begin
				hold_ff <= 1'b0;
				wd_low_ff <= 1'b0;
				hold_cnt_ff <= 32'h0;
			end else if (wd_expire) begin
				hold_ff <= 1'b1;
				wd_low_ff <= 1'b1;
				hold_cnt_ff <= 32'h0;
			end else if (hold_ff) begin
				if (hold_cnt_ff == IRQ_HOLD_CYC - 32'h1) begin
					hold_ff <= 1'b0;
					wd_low_ff <= 1'b0;
				end else begin
					hold_cnt_ff <= hold_cnt_ff + 32'h1;
					if (step && pre_ovf) begin
						wd_low_ff <= 1'b0;
					end
				end
			end
		end
	end

	// Interrupt pin, gated by the interrupt enable.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			timer_irq_n_ff <= 1'b1;
		end else if (CE_IN) begin
			timer_irq_n_ff <= !(timer_irq_enable && ((wd_low_ff && !pf_mode) ||
				(expired_ff && pf_mode)));
		end
	end

	// Write response: unmapped or read-only offsets answer SLVERR.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (CE_IN) begin
			if (wr_fire) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (AXI_AWADDR_IN == CTRL_OFS ||
					AXI_AWADDR_IN == STATUS_OFS || AXI_AWADDR_IN == TARGET_OFS ||
					AXI_AWADDR_IN == PTARGET_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (AXI_BREADY_IN) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read multiplexer.
	always_comb begin
		rd_hit = 1'b1;
		unique case (AXI_ARADDR_IN)
			CTRL_OFS: rd_word = {26'h0, ctrl_ff};
			STATUS_OFS: rd_word = {28'h0, !timer_irq_n_ff, battery, run_ff,
				timer_flag_ff};
			TARGET_OFS: rd_word = {24'h0, timer_target_ff};
			PTARGET_OFS: rd_word = {24'h0, prescale_target_ff};
			COUNT_OFS: rd_word = {24'h0, timer_count_ff};
			PCOUNT_OFS: rd_word = {24'h0, prescale_count_ff};
			default: begin
				rd_word = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data channel.
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0;
		end else if (CE_IN) begin
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (AXI_RREADY_IN) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Checks on the timer behaviour.
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	flag_set_a: assert property (CE_IN && (wd_expire || pf_expire) |=> timer_flag_ff) else $error("expiry did not set flag");
	start_restart_a: assert property (CE_IN && wd_go && timer_enable && start_pulse && en_q_ff |=> timer_count_ff == 8'h01 && prescale_count_ff == 8'h01) else $error("start did not restart");
	sel_off_a: assert property (timer_clock_select == 2'h0 |-> !step && !wd_expire && !pf_expire) else $error("counting with select 00");
	enable_load_a: assert property (CE_IN && en_rise && !pf_mode && timer_target_ff != 8'h00 |=> timer_count_ff == 8'h01) else $error("enable did not load one");
	bad_target_a: assert property (CE_IN && en_rise && !pf_mode && timer_target_ff == 8'h00 |=> !run_ff && timer_count_ff == 8'h00) else $error("ran with target zero");
	pre_reload_a: assert property (CE_IN && step && pre_ovf && !start_pulse && !flag_clear |=> prescale_count_ff == 8'h01) else $error("prescaler not reloaded");
	wd_periodic_a: assert property (CE_IN && wd_expire |=> timer_count_ff == 8'h01 && run_ff && hold_ff) else $error("watchdog not restarted");
	hold_cap_a: assert property (wd_low_ff |-> hold_ff && hold_cnt_ff < IRQ_HOLD_CYC) else $error("pulse exceeds cap");
	pf_stop_a: assert property (CE_IN && pf_expire |=> timer_count_ff == COUNT_MAX && expired_ff ##1 !pf_go) else $error("power-fail did not stop");
	clear_restart_a: assert property (CE_IN && flag_clear && pf_mode && expired_ff && en_q_ff && timer_enable |=> !expired_ff && timer_count_ff == 8'h01) else $error("clear did not restart");
	disable_a: assert property (CE_IN && !timer_enable |=> timer_count_ff == 8'h00 && prescale_count_ff == 8'h01) else $error("disable did not reset counts");
	irq_gate_a: assert property (CE_IN && !timer_irq_enable |=> TIMER_IRQ_N_OUT) else $error("interrupt not gated");
	pf_keep_a: assert property (CE_IN && pf_mode && en_q_ff && timer_enable && !battery && !flag_clear |=> $stable(timer_count_ff)) else $error("count lost on main supply");

	wd_expire_c: cover property (wd_expire);
	pf_expire_c: cover property (pf_expire);
	start_c: cover property (wd_go && start_pulse && timer_count_ff > 8'h01);
	pause_c: cover property (wd_pause ##1 !hold_ff);

endmodule : bus_watchdog_powerfail_timer

// File: hdl/timer_pkg.sv
/*
 * Shared constants for the bus watchdog and power-fail timer: register
 * offsets, control field positions, reset values and timing figures.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package timer_pkg;

	// System clock period in nanoseconds.
	localparam int unsigned CLK_PERIOD_NS = 25;

	// Tick periods for clock select settings 01, 10 and 11, in nanoseconds.
	localparam int unsigned TICK_SEL1_NS = 244000;
	localparam int unsigned TICK_SEL2_NS = 10000000;
	localparam int unsigned TICK_SEL3_NS = 1000000000;
	localparam int unsigned TICK_SEL1_CYC = TICK_SEL1_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_SEL2_CYC = TICK_SEL2_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_SEL3_CYC = TICK_SEL3_NS / CLK_PERIOD_NS;

	// Longest watchdog interrupt pulse, in nanoseconds and in cycles.
	localparam int unsigned IRQ_HOLD_NS = 210000000;
	localparam int unsigned IRQ_HOLD_CYC_DEF = IRQ_HOLD_NS / CLK_PERIOD_NS;

	// Prescaler count used while the prescale target register is zero.
	localparam logic [7:0] DEF_PRESCALE_COUNT = 8'h40;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] TARGET_OFS = 8'h08;
	localparam logic [7:0] PTARGET_OFS = 8'h0c;
	localparam logic [7:0] COUNT_OFS = 8'h10;
	localparam logic [7:0] PCOUNT_OFS = 8'h14;

	// Control register field positions.
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_SEL_LSB = 1;
	localparam int unsigned CTRL_IRQEN_BIT = 3;
	localparam int unsigned CTRL_MODE_BIT = 4;
	localparam int unsigned CTRL_PF_BIT = 5;

	// Values after reset, and the highest count.
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [7:0] TARGET_RST = 8'h00;
	localparam logic [7:0] PTARGET_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PCOUNT_RST = 8'h01;
	localparam logic [7:0] COUNT_MAX = 8'hff;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_pkg

// File: hdl/timer_pin_sync.sv
/*
 * Brings the serial bus clock and data pins and the battery indicator into
 * the system clock domain and turns a start condition into a one-cycle
 * pulse. Assumes all three inputs are asynchronous to the clock.
 */
`timescale 1ns/1ps
module timer_pin_sync (
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// Asynchronous pins.
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic battery_in,
	// Synchronised results.
	output logic start_pulse_out,
	output logic battery_out
);

	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic [1:0] prev_ff;
	logic start_ff;

	// Two flip-flops per pin, then a delayed copy of clock and data.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			meta_ff <= 3'h7;
			sync_ff <= 3'h7;
			prev_ff <= 2'h3;
		end else if (ce_in) begin
			meta_ff <= {battery_in, sda_in, scl_in};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff[1:0];
		end
	end

	// Data falling while the clock stays high marks a start condition.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			start_ff <= 1'b0;
		end else if (ce_in) begin
			start_ff <= sync_ff[0] && prev_ff[0] && prev_ff[1] && !sync_ff[1];
		end
	end

	assign start_pulse_out = start_ff;
	assign battery_out = sync_ff[2];

endmodule : timer_pin_sync

// File: testbench/serial_host_model.sv
/*
 * Behavioural host on the two-wire serial bus: makes one start and stop
 * condition per request. Both lines have pull-ups, so they idle high.
 */
`timescale 1ns/1ps
module serial_host_model #(
	parameter int unsigned HALF = 2
) (
	// Clock and request.
	input wire logic clk_in,
	input wire logic go_in,
	// Bus lines and state.
	output logic busy_out,
	output logic scl_out,
	output logic sda_out
);
	// Start while the clock line is high, then a stop to release the bus.
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
		busy_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (go_in === 1'b1) begin
				busy_out <= 1'b1;
				sda_out <= 1'b0;
				repeat (HALF) @(posedge clk_in);
				scl_out <= 1'b0;
				repeat (HALF) @(posedge clk_in);
				scl_out <= 1'b1;
				repeat (HALF) @(posedge clk_in);
				sda_out <= 1'b1;
				busy_out <= 1'b0;
			end
		end
	end
endmodule : serial_host_model

// File: testbench/bus_watchdog_powerfail_timer_test.sv
/*
 * Self-checking bench for the bus watchdog and power-fail timer.
 * Assumes the timer package, the design and the serial host model.
 */
`timescale 1ns/1ps
module bus_watchdog_powerfail_timer_test;
	import timer_pkg::*;
	localparam logic [33:0] FULL = '1;
	localparam logic [33:0] RSP = {2'b11, 32'h0};
	localparam logic [33:0] B0 = {2'b11, 32'h1};
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, battery = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd_val, v;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, irq_d = 1'b1, ce = 1'b1;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq_n, scl, sda, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] got, exp_q[$], msk_q[$];
	int unsigned errors = 0, cmp_count = 0, f0, cyc = 0, falls = 0;
	int unsigned fall_t = 0, period = 0, low_w = 0, last_w = 0;

	// Clock generator.
	initial begin
		forever #12.5 clk = ~clk;
	end

	// Design with short tick, hold and default prescale counts.
	bus_watchdog_powerfail_timer #(.TICK_CYC_SEL1(4), .TICK_CYC_SEL2(5),
		.TICK_CYC_SEL3(6), .IRQ_HOLD_CYC(30), .DEF_PRESCALE(8'h03)) dut (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
		.AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
		.AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
		.AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
		.AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
		.AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
		.AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready), .SCL_IN(scl), .SDA_IN(sda),
		.BATTERY_MODE_IN(battery), .TIMER_IRQ_N_OUT(irq_n));

	// Host on the monitored serial bus.
	serial_host_model host (.clk_in(clk), .go_in(go), .busy_out(busy),
		.scl_out(scl), .sda_out(sda));

	task automatic stop_test();
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [33:0] seen, input logic [33:0] e);
		cmp_count++;
		if (seen !== e) begin
			errors++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, e);
		end
	endtask : check

	task automatic truth(input logic c);
		check({33'h0, c}, 34'h1);
	endtask : truth

	function automatic logic [33:0] ok(input logic [7:0] d);
		return {RESP_OKAY, 24'h0, d};
	endfunction : ok

	// Write both channels together and hold bready until the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		msk_q.push_back(RSP);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	// Read one word; the low byte is kept for range checks.
	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		input logic [33:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rd_val = rdata[7:0];
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic wait_flag(input int unsigned n);
		for (int unsigned i = 0; i < n; i++) begin
			rd(STATUS_OFS, ok(8'h00), RSP);
			if (rd_val[0] === 1'b1) break;
			repeat (10) @(posedge clk);
		end
	endtask : wait_flag

	task automatic start_cond();
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
	endtask : start_cond

	// Compares each bus answer with the oldest noted expectation.
	always @(posedge clk) begin
		if ((bvalid && bready) === 1'b1 || (rvalid && rready) === 1'b1) begin
			got = (bvalid === 1'b1) ? {bresp, 32'h0} : {rresp, rdata};
			if (exp_q.size() == 0) check(1'b1, 1'b0);
			else check(got & msk_q.pop_front(), exp_q.pop_front());
		end
	end

	// Measures interrupt low width and time between falling edges.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		irq_d <= irq_n;
		if (irq_n === 1'b0) low_w <= low_w + 1;
		if (irq_d === 1'b1 && irq_n === 1'b0) begin
			falls <= falls + 1;
			period <= cyc - fall_t;
			fall_t <= cyc;
			low_w <= 1;
		end
		if (irq_d === 1'b0 && irq_n === 1'b1) last_w <= low_w;
	end

	// Cuts a hang short.
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		stop_test();
	end

	// Main sequence.
	initial begin
		void'($urandom(65));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(CTRL_OFS, ok({2'b00, CTRL_RST}), FULL);
		rd(STATUS_OFS, ok(8'h00), FULL);
		rd(TARGET_OFS, ok(TARGET_RST), FULL);
		rd(PTARGET_OFS, ok(PTARGET_RST), FULL);
		rd(COUNT_OFS, ok(COUNT_RST), FULL);
		rd(PCOUNT_OFS, ok(PCOUNT_RST), FULL);
		rd(8'h18, {RESP_SLVERR, 32'h0}, FULL);
		wr(COUNT_OFS, 32'h5, RESP_SLVERR);
		rd(COUNT_OFS, ok(COUNT_RST), FULL);
		v = 8'($urandom);
		wr(TARGET_OFS, {24'h0, v}, RESP_OKAY);
		rd(TARGET_OFS, ok(v), FULL);
		// A write with the low byte lane off stores nothing.
		wstrb <= 4'h0;
		wr(TARGET_OFS, {24'h0, ~v}, RESP_OKAY);
		wstrb <= 4'hf;
		rd(TARGET_OFS, ok(v), FULL);
		// Enabling with a zero target leaves the timer off.
		wr(TARGET_OFS, 32'h0, RESP_OKAY);
		wr(CTRL_OFS, 32'h0b, RESP_OKAY);
		repeat (60) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), FULL);
		wr(TARGET_OFS, 32'h2, RESP_OKAY);
		repeat (60) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), FULL);
		// Watchdog loads one, and select 00 holds it there.
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wr(PTARGET_OFS, 32'h2, RESP_OKAY);
		wr(CTRL_OFS, 32'h09, RESP_OKAY);
		repeat (60) @(posedge clk);
		rd(COUNT_OFS, ok(8'h01), FULL);
		rd(STATUS_OFS, ok(8'h00), B0);
		wr(CTRL_OFS, 32'h0b, RESP_OKAY);
		repeat (300) @(posedge clk);
		truth(falls >= 2);
		truth(last_w >= 5 && last_w <= 9);
		truth(period >= 30 && period <= 50);
		rd(STATUS_OFS, ok(8'h01), B0);
		wr(CTRL_OFS, 32'h03, RESP_OKAY);
		f0 = falls;
		repeat (120) @(posedge clk);
		truth(falls == f0 && irq_n === 1'b1);
		// Start conditions keep a long interval from expiring.
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		rd(COUNT_OFS, ok(8'h00), FULL);
		rd(PCOUNT_OFS, ok(8'h01), FULL);
		wr(STATUS_OFS, 32'h0, RESP_OKAY);
		wr(TARGET_OFS, 32'd20, RESP_OKAY);
		wr(CTRL_OFS, 32'h0b, RESP_OKAY);
		f0 = falls;
		repeat (6) begin
			repeat (40 + $urandom % 60) @(posedge clk);
			start_cond();
		end
		truth(falls == f0);
		rd(STATUS_OFS, ok(8'h00), B0);
		wait_flag(40);
		rd(STATUS_OFS, ok(8'h01), B0);
		// Power-fail counting on battery only.
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wr(STATUS_OFS, 32'h0, RESP_OKAY);
		wr(PTARGET_OFS, 32'h1, RESP_OKAY);
		wr(TARGET_OFS, 32'h2, RESP_OKAY);
		wr(CTRL_OFS, 32'h2b, RESP_OKAY);
		repeat (100) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), FULL);
		battery <= 1'b1;
		repeat (600) @(posedge clk);
		battery <= 1'b0;
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= 120 && rd_val <= 170);
		repeat (200) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= 120 && rd_val <= 170);
		rd(STATUS_OFS, ok(8'h00), B0);
		battery <= 1'b1;
		wait_flag(200);
		rd(COUNT_OFS, ok(COUNT_MAX), FULL);
		repeat (100) @(posedge clk);
		rd(COUNT_OFS, ok(COUNT_MAX), FULL);
		truth(irq_n === 1'b0);
		wr(STATUS_OFS, 32'h0, RESP_OKAY);
		repeat (4) @(posedge clk);
		truth(irq_n === 1'b1);
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= 1 && rd_val < 10);
		wait_flag(200);
		wr(CTRL_OFS, 32'h2a, RESP_OKAY);
		rd(COUNT_OFS, ok(8'h00), FULL);
		wr(CTRL_OFS, 32'h2b, RESP_OKAY);
		repeat (40) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= 1 && rd_val < 20);
		rd(STATUS_OFS, ok(8'h01), B0);
		// Every clock select in both modes.
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 4; s++) begin
				wr(CTRL_OFS, 32'h0, RESP_OKAY);
				wr(STATUS_OFS, 32'h0, RESP_OKAY);
				wr(CTRL_OFS, 32'h19 | (s << 1) | (m << 5), RESP_OKAY);
				wait_flag(150);
				rd(STATUS_OFS, ok({7'h0, s != 0}), B0);
			end
		end
		// Zero prescale target falls back to the default count.
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		wr(PTARGET_OFS, 32'h0, RESP_OKAY);
		wr(CTRL_OFS, 32'h2b, RESP_OKAY);
		repeat (240) @(posedge clk);
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= 15 && rd_val <= 25);
		// Clock enable low freezes the counters.
		v = rd_val;
		ce <= 1'b0;
		repeat (50) @(posedge clk);
		ce <= 1'b1;
		rd(COUNT_OFS, ok(8'h00), RSP);
		truth(rd_val >= v && rd_val <= v + 8'h1);
		stop_test();
	end
endmodule : bus_watchdog_powerfail_timer_test
